/* hw/nmv_defines.svh */
// constants for the nibble core move-group decoder
`ifndef NMV_DEFINES_SVH
`define NMV_DEFINES_SVH
`define NMV_OP_LD_A_IND 8'h0C
`define NMV_OP_LD_A_DIR 8'h3C
`define NMV_OP_LD_HL_DIR 8'h28
`define NMV_OP_LD_TBL_LO 8'h33
`define NMV_OP_LD_TBL_HI 8'h32
`define NMV_OP_ST_IND 8'h0F
`define NMV_OP_ST_IND_INC 8'h1A
`define NMV_OP_ST_IND_DEC 8'h1B
`define NMV_OP_ST_DIR 8'h3F
`define NMV_NIB_LD_A_IMM 4'h4
`define NMV_NIB_LD_H_IMM 4'hC
`define NMV_NIB_LD_L_IMM 4'hE
`define NMV_NIB_ST_IMM_INC 4'hF
`define NMV_HL_ALIGN_MASK 8'hFC
`define NMV_TC_W 12
`define NMV_TC_RST 12'h000
`define NMV_NIB_RST 4'h0
`define NMV_CLKS_PER_CYC 2
`define NMV_DMEM_DEPTH 256
`endif

/* hw/nmv_pkg.sv */
// types for the nibble core move-group decoder
package nmv_pkg;
    typedef enum logic [0:0] {
        NMV_IDLE,
        NMV_EXEC
    } nmv_state_t;
endpackage

/* hw/nmv_dmem.sv */
// 4-bit data memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "nmv_defines.svh"
module nmv_dmem (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire logic [3:0] i_wdata,
    input wire logic [7:0] i_raddr,
    output logic [3:0] o_rdata
);
    logic [3:0] mem_q [0:`NMV_DMEM_DEPTH-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    // no reset: contents are undefined until software writes them
    always_ff @(posedge i_clk) begin
        o_rdata <= mem_q[i_raddr];
    end
endmodule
`default_nettype wire

/* hw/nmv_core.sv */
// decode and execute of the data-move instruction group
// How it works
// - opcode 0C loads the accumulator from memory at the pointer pair, zero from result, status 1, carry kept, one cycle.
// - opcode 3C with an address byte loads the accumulator from that word, zero from result, status 1, two cycles.
// - opcode 28 clears the two low address bits, loads the low pointer from that word and the high pointer from the next, two cycles.
// - opcodes 4k load immediate k into the accumulator in one cycle, zero from result, status 1.
// - opcode 33 loads the low nibble of the table word at the table counter, zero from result, status 1, two cycles.
// - opcode 32 loads the high nibble of that table word then increments the table counter, zero from result, status 1, two cycles.
// - opcode 1A stores the accumulator at the pointer pair and increments the low pointer, status is the inverted carry, zero from the low pointer, one cycle.
// - opcode 3F with an address byte stores the accumulator there, carry and zero kept, status 1, two cycles.
// - indirect addresses are the high pointer as upper nibble joined to the low pointer as lower nibble.
`timescale 1ns/100ps
`default_nettype none
`include "nmv_defines.svh"
module nmv_core (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_op_valid,
    input wire logic [7:0] i_op,
    input wire logic [7:0] i_op_arg,
    output logic o_op_ready,
    output logic o_op_done,
    output logic o_op_unknown,
    output logic [`NMV_TC_W-1:0] o_tbl_addr,
    input wire logic [7:0] i_tbl_data,
    input wire logic i_tc_load,
    input wire logic [`NMV_TC_W-1:0] i_tc_value,
    output logic [3:0] o_accumulator_reg,
    output logic [3:0] o_pointer_high_reg,
    output logic [3:0] o_pointer_low_reg,
    output logic [`NMV_TC_W-1:0] o_table_counter,
    output logic o_carry_flag,
    output logic o_zero_flag,
    output logic o_status_flag
);
    nmv_pkg::nmv_state_t state_q;
    logic [7:0] op_q;
    logic [7:0] arg_q;
    logic [1:0] step_q;
    logic [1:0] last_step;
    logic known;
    logic [3:0] acc_q;
    logic [3:0] acc_d;
    logic [3:0] hr_q;
    logic [3:0] lr_q;
    logic [`NMV_TC_W-1:0] tc_q;
    logic cf_q;
    logic zf_q;
    logic sf_q;
    logic [7:0] hl_addr;
    logic [7:0] pair_addr;
    logic [7:0] raddr;
    logic [3:0] rdata;
    logic mem_we;
    logic [7:0] waddr;
    logic [3:0] wdata;
    logic [4:0] lr_inc;
    logic [4:0] lr_dec;
    logic fin;

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign hl_addr = {hr_q, lr_q};
    assign pair_addr = arg_q & `NMV_HL_ALIGN_MASK;
    assign lr_inc = {1'b0, lr_q} + 5'h01;
    assign lr_dec = {1'b0, lr_q} - 5'h01;

    // two clocks per instruction cycle: memory read data lags one clock
    always_comb begin
        case (op_q)
            `NMV_OP_LD_A_DIR,
            `NMV_OP_LD_HL_DIR,
            `NMV_OP_LD_TBL_LO,
            `NMV_OP_LD_TBL_HI,
            `NMV_OP_ST_DIR: last_step = 2'h3;
            default: last_step = 2'h1;
        endcase
    end

    always_comb begin
        known = 1'b1;
        case (op_q)
            `NMV_OP_LD_A_IND, `NMV_OP_LD_A_DIR, `NMV_OP_LD_HL_DIR,
            `NMV_OP_LD_TBL_LO, `NMV_OP_LD_TBL_HI, `NMV_OP_ST_IND,
            `NMV_OP_ST_IND_INC, `NMV_OP_ST_IND_DEC, `NMV_OP_ST_DIR: ;
            default: begin
                if (op_q[7:4] != `NMV_NIB_LD_A_IMM
                    && op_q[7:4] != `NMV_NIB_LD_H_IMM
                    && op_q[7:4] != `NMV_NIB_LD_L_IMM
                    && op_q[7:4] != `NMV_NIB_ST_IMM_INC) begin
                    known = 1'b0;
                end
            end
        endcase
    end

    assign fin = (state_q == nmv_pkg::NMV_EXEC) && (step_q == last_step);
    assign o_op_ready = (state_q == nmv_pkg::NMV_IDLE);
    assign o_op_done = fin;
    assign o_op_unknown = fin && !known;

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= nmv_pkg::NMV_IDLE;
            step_q <= 2'h0;
            op_q <= 8'h00;
            arg_q <= 8'h00;
        end else if (state_q == nmv_pkg::NMV_IDLE) begin
            step_q <= 2'h0;
            if (i_op_valid) begin
                state_q <= nmv_pkg::NMV_EXEC;
                op_q <= i_op;
                arg_q <= i_op_arg;
            end
        end else if (fin) begin
            state_q <= nmv_pkg::NMV_IDLE;
        end else begin
            step_q <= step_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory
    always_comb begin
        raddr = hl_addr;
        if (op_q == `NMV_OP_LD_A_DIR) begin
            raddr = arg_q;
        end else if (op_q == `NMV_OP_LD_HL_DIR) begin
            raddr = (step_q[1]) ? (pair_addr | 8'h01) : pair_addr;
        end
    end

    always_comb begin
        mem_we = 1'b0;
        waddr = hl_addr;
        wdata = acc_q;
        if (state_q == nmv_pkg::NMV_EXEC && step_q == 2'h0) begin
            if (op_q == `NMV_OP_ST_IND || op_q == `NMV_OP_ST_IND_DEC) begin
                mem_we = 1'b1;
            end else if (op_q == `NMV_OP_ST_IND_INC) begin
                mem_we = 1'b1;
            end else if (op_q == `NMV_OP_ST_DIR) begin
                mem_we = 1'b1;
                waddr = arg_q;
            end else if (op_q[7:4] == `NMV_NIB_ST_IMM_INC) begin
                mem_we = 1'b1;
                wdata = op_q[3:0];
            end
        end
    end

    nmv_dmem u_dmem (
        .i_clk(i_clk),
        .i_we(mem_we),
        .i_waddr(waddr),
        .i_wdata(wdata),
        .i_raddr(raddr),
        .o_rdata(rdata)
    );

    assign o_tbl_addr = tc_q;

    ////////////////////////////////////////////////////////////////////////
    // accumulator and zero/status for accumulator loads
    // one-cycle loads finish on the load edge, so zero must see the new value
    always_comb begin
        acc_d = acc_q;
        if (state_q == nmv_pkg::NMV_EXEC && step_q == 2'h1) begin
            if (op_q == `NMV_OP_LD_A_IND || op_q == `NMV_OP_LD_A_DIR) begin
                acc_d = rdata;
            end else if (op_q[7:4] == `NMV_NIB_LD_A_IMM) begin
                acc_d = op_q[3:0];
            end else if (op_q == `NMV_OP_LD_TBL_LO) begin
                acc_d = i_tbl_data[3:0];
            end else if (op_q == `NMV_OP_LD_TBL_HI) begin
                acc_d = i_tbl_data[7:4];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            acc_q <= `NMV_NIB_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    // pointer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hr_q <= `NMV_NIB_RST;
            lr_q <= `NMV_NIB_RST;
        end else if (state_q == nmv_pkg::NMV_EXEC) begin
            if (op_q == `NMV_OP_LD_HL_DIR && step_q == 2'h1) begin
                lr_q <= rdata;
            end else if (op_q == `NMV_OP_LD_HL_DIR && step_q == 2'h3) begin
                hr_q <= rdata;
            end else if (step_q == 2'h1) begin
                if (op_q == `NMV_OP_ST_IND_INC
                    || op_q[7:4] == `NMV_NIB_ST_IMM_INC) begin
                    lr_q <= lr_inc[3:0];
                end else if (op_q == `NMV_OP_ST_IND_DEC) begin
                    lr_q <= lr_dec[3:0];
                end else if (op_q[7:4] == `NMV_NIB_LD_H_IMM) begin
                    hr_q <= op_q[3:0];
                end else if (op_q[7:4] == `NMV_NIB_LD_L_IMM) begin
                    lr_q <= op_q[3:0];
                end
            end
        end
    end

    // table counter; a software load loses only to the increment when opcode 32 finishes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tc_q <= `NMV_TC_RST;
        end else if (fin && op_q == `NMV_OP_LD_TBL_HI) begin
            tc_q <= tc_q + `NMV_TC_W'(1);
        end else if (i_tc_load) begin
            tc_q <= i_tc_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags, updated when a known instruction finishes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cf_q <= 1'b0;
            zf_q <= 1'b0;
            sf_q <= 1'b1;
        end else if (fin && known) begin
            // carry is never touched by this group
            sf_q <= 1'b1;
            if (op_q == `NMV_OP_LD_A_IND || op_q == `NMV_OP_LD_A_DIR
                || op_q == `NMV_OP_LD_TBL_LO || op_q == `NMV_OP_LD_TBL_HI
                || op_q[7:4] == `NMV_NIB_LD_A_IMM) begin
                zf_q <= (acc_d == 4'h0);
            end else if (op_q == `NMV_OP_ST_IND_INC
                || op_q[7:4] == `NMV_NIB_ST_IMM_INC) begin
                // low pointer moves on this same edge: use its new value
                zf_q <= (lr_inc[3:0] == 4'h0);
                sf_q <= !lr_inc[4];
            end else if (op_q == `NMV_OP_ST_IND_DEC) begin
                zf_q <= (lr_dec[3:0] == 4'h0);
                sf_q <= !lr_dec[4];
            end
        end
    end

    assign o_accumulator_reg = acc_q;
    assign o_pointer_high_reg = hr_q;
    assign o_pointer_low_reg = lr_q;
    assign o_table_counter = tc_q;
    assign o_carry_flag = cf_q;
    assign o_zero_flag = zf_q;
    assign o_status_flag = sf_q;
endmodule
`default_nettype wire

/* dv/nmv_tbl_rom.sv */
// table program memory model answering by address
`timescale 1ns/100ps
`default_nettype none
module nmv_tbl_rom (
    input wire logic [11:0] i_addr,
    output logic [7:0] o_data
);
    // pattern differs per address so a wrong fetch shows
    assign o_data = i_addr[7:0] ^ {i_addr[3:0], i_addr[11:8]};
endmodule
`default_nettype wire

/* dv/nmv_core_asserts.sv */
// concurrent checks on the move-group decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "nmv_defines.svh"
module nmv_core_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_op_valid,
    input wire logic [7:0] i_op,
    input wire logic o_op_ready,
    input wire logic o_op_done,
    input wire logic [3:0] o_accumulator_reg,
    input wire logic [3:0] o_pointer_low_reg,
    input wire logic [`NMV_TC_W-1:0] o_table_counter,
    input wire logic o_carry_flag,
    input wire logic o_zero_flag,
    input wire logic o_status_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic take = i_op_valid & o_op_ready;
    wire logic [3:0] op_lo = i_op[3:0];
    wire logic acc_zero = o_accumulator_reg == 4'h0;
    sequence s_one;
        !o_op_done ##1 o_op_done;
    endsequence
    sequence s_two;
        !o_op_done [*3] ##1 o_op_done;
    endsequence
    //////////////////////////////////////////////////////////
    one_cycle_done_a: assert property (
        take && (i_op == 8'h0C || i_op == 8'h1A || i_op[7:4] == 4'h4)
        |=> s_one) else $error("one-cycle move done late");
    two_cycle_done_a: assert property (
        take && i_op inside {8'h3C, 8'h28, 8'h33, 8'h32, 8'h3F} |=> s_two)
        else $error("two-cycle move done at wrong time");
    ind_load_flags_a: assert property (take && i_op == 8'h0C |-> ##3
        (o_status_flag && o_zero_flag == acc_zero
        && o_carry_flag == $past(o_carry_flag, 3)))
        else $error("indirect load flags wrong");
    imm_load_value_a: assert property (take && i_op[7:4] == 4'h4
        |-> ##3 (o_accumulator_reg == $past(op_lo, 3) && o_status_flag))
        else $error("immediate load value wrong");
    dir_load_flags_a: assert property (take && i_op == 8'h3C |-> ##5
        (o_status_flag && o_zero_flag == acc_zero))
        else $error("direct load flags wrong");
    store_inc_low_a: assert property (take && i_op == 8'h1A |-> ##3
        (o_pointer_low_reg == $past(o_pointer_low_reg, 3) + 4'h1
        && o_status_flag == ($past(o_pointer_low_reg, 3) != 4'hF)
        && o_zero_flag == (o_pointer_low_reg == 4'h0)))
        else $error("store with increment wrong");
    dir_store_flags_a: assert property (take && i_op == 8'h3F |-> ##5
        (o_carry_flag == $past(o_carry_flag, 5) && o_status_flag
        && o_zero_flag == $past(o_zero_flag, 5)))
        else $error("direct store flags wrong");
    table_high_inc_a: assert property (take && i_op == 8'h32 |-> ##5
        o_table_counter == $past(o_table_counter, 5) + 12'h001)
        else $error("table counter not incremented");
endmodule
`default_nettype wire

/* dv/nibble_cpu_move_instructions_test.sv */
// self-checking bench for the move-group decoder
`timescale 1ns/100ps
`default_nettype none
`include "nmv_defines.svh"
module nibble_cpu_move_instructions_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_op_valid = 1'b0;
    logic i_tc_load = 1'b0;
    logic [7:0] i_op = 8'h00;
    logic [7:0] i_op_arg = 8'h00;
    logic [11:0] i_tc_value = 12'h000;
    wire logic o_op_ready, o_op_done, o_op_unknown;
    wire logic o_carry_flag, o_zero_flag, o_status_flag;
    wire logic [11:0] o_tbl_addr, o_table_counter;
    wire logic [7:0] i_tbl_data;
    wire logic [3:0] o_accumulator_reg, o_pointer_high_reg, o_pointer_low_reg;
    logic [3:0] m_acc, m_hr, m_lr;
    logic [11:0] m_tc;
    logic m_zf, m_sf;
    logic [3:0] mem [256];
    logic [7:0] op;
    // 8'h01 is outside the move group and must leave all state alone
    logic [7:0] ops [16] = '{8'h0C, 8'h3C, 8'h28, 8'h33, 8'h32, 8'h1A,
        8'h3F, 8'h40, 8'hC0, 8'hE0, 8'h0F, 8'h1B, 8'hF0, 8'h0C, 8'h1A,
        8'h01};
    logic [15:0] rnd = 16'h8AE4;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    nmv_core DUT (.i_clk, .i_rst, .i_op_valid, .i_op, .i_op_arg, .o_op_ready,
        .o_op_done, .o_op_unknown, .o_tbl_addr, .i_tbl_data, .i_tc_load,
        .i_tc_value, .o_accumulator_reg, .o_pointer_high_reg,
        .o_pointer_low_reg, .o_table_counter, .o_carry_flag, .o_zero_flag,
        .o_status_flag);
    nmv_tbl_rom u_rom (.i_addr(o_tbl_addr), .o_data(i_tbl_data));
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    //////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] r);
        return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction
    function automatic logic [27:0] st();
        return {o_accumulator_reg, o_pointer_high_reg, o_pointer_low_reg,
            o_table_counter, o_carry_flag, o_zero_flag, o_status_flag,
            o_op_ready};
    endfunction
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lda(input logic [3:0] v);
        m_acc = v;
        m_zf = v == 4'h0;
        m_sf = 1'b1;
    endtask
    task automatic ldtc(input logic [11:0] v);
        @(posedge i_clk);
        i_tc_load <= 1'b1;
        i_tc_value <= v;
        @(posedge i_clk);
        i_tc_load <= 1'b0;
        m_tc = v;
    endtask
    task automatic run(input logic [7:0] o, input logic [7:0] arg);
        int n;
        logic [7:0] t;
        logic two;
        logic unk;
        n = 0;
        unk = !(o inside {8'h0C, 8'h3C, 8'h28, 8'h33, 8'h32, 8'h1A, 8'h3F,
            8'h0F, 8'h1B} || o[7:4] inside {4'h4, 4'hC, 4'hE, 4'hF});
        // table word mirrors the model pattern at the old counter
        t = o_pat(m_tc);
        two = o inside {8'h3C, 8'h28, 8'h33, 8'h32, 8'h3F};
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op <= o;
        i_op_arg <= arg;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_op_done !== 1'b1 && n < 8);
        chk(28'(n), two ? 28'(2 * `NMV_CLKS_PER_CYC)
            : 28'(`NMV_CLKS_PER_CYC));
        chk(28'(o_op_unknown), 28'(unk));
        case (o) inside
            8'h0C: lda(mem[{m_hr, m_lr}]);
            8'h3C: lda(mem[arg]);
            8'h28: {m_hr, m_lr, m_sf} = {
                mem[(arg & `NMV_HL_ALIGN_MASK) | 8'h01],
                mem[arg & `NMV_HL_ALIGN_MASK], 1'b1};
            8'h33: lda(t[3:0]);
            8'h32: begin
                lda(t[7:4]);
                m_tc++;
            end
            8'h1A: begin
                mem[{m_hr, m_lr}] = m_acc;
                m_sf = m_lr != 4'hF;
                m_lr++;
                m_zf = m_lr == 4'h0;
            end
            8'h3F: {mem[arg], m_sf} = {m_acc, 1'b1};
            8'h0F: {mem[{m_hr, m_lr}], m_sf} = {m_acc, 1'b1};
            8'h1B: begin
                mem[{m_hr, m_lr}] = m_acc;
                m_sf = m_lr != 4'h0;
                m_lr--;
                m_zf = m_lr == 4'h0;
            end
            [8'hF0:8'hFF]: begin
                mem[{m_hr, m_lr}] = o[3:0];
                m_sf = m_lr != 4'hF;
                m_lr++;
                m_zf = m_lr == 4'h0;
            end
            [8'h40:8'h4F]: lda(o[3:0]);
            [8'hC0:8'hCF]: {m_hr, m_sf} = {o[3:0], 1'b1};
            [8'hE0:8'hEF]: {m_lr, m_sf} = {o[3:0], 1'b1};
        endcase
        @(posedge i_clk);
        @(negedge i_clk);
        chk(st(), {m_acc, m_hr, m_lr, m_tc, 1'b0, m_zf, m_sf, 1'b1});
        chk(28'(o_tbl_addr), 28'(m_tc));
    endtask
    function automatic logic [7:0] o_pat(input logic [11:0] a);
        return a[7:0] ^ {a[3:0], a[11:8]};
    endfunction
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////
    initial begin
        {m_acc, m_hr, m_lr, m_tc, m_zf, m_sf} = {24'h000000, 2'b01};
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk(st(), {24'h000000, 4'h3});
        // fill all of data memory first: contents are unknown after reset
        for (int i = 0; i < 256; i++) begin
            rnd = nxt(rnd);
            run({4'h4, rnd[3:0]}, 8'h00);
            run(8'h3F, 8'(i));
        end
        run(8'h40, 8'h00);
        ldtc(12'hFFF);
        run(8'h32, 8'h00);
        for (int i = 0; i < 400; i++) begin
            rnd = nxt(rnd);
            op = ops[rnd[3:0]];
            if (op[3:0] == 4'h0 && op[7:6] != 2'b00) op[3:0] = rnd[7:4];
            if (rnd[6:4] == 3'h0) ldtc(rnd[15:4]);
            run(op, rnd[15:8]);
        end
        final_report();
    end
endmodule
bind nmv_core nmv_core_asserts u_chk (.i_clk, .i_rst, .i_op_valid, .i_op,
    .o_op_ready, .o_op_done, .o_accumulator_reg, .o_pointer_low_reg,
    .o_table_counter, .o_carry_flag, .o_zero_flag, .o_status_flag);
`default_nettype wire
